/* hdl/decode_defs.svh */
`ifndef DECODE_DEFS_SVH
`define DECODE_DEFS_SVH

`define OPC_CARRY_INV 8'hf5
`define OPC_FLAGS_OUT 8'h9f
`define OPC_FLAGS_POP 8'h9d
`define OPC_FLAGS_PUSH 8'h9c
`define OPC_FLAGS_IN 8'h9e
`define OPC_CARRY_SET 8'hf9
`define OPC_DIR_SET 8'hfd
`define OPC_INT_SET 8'hfb
// top-bit masks for opcode families
`define MASK_HI6 8'hfc
`define MASK_HI7 8'hfe
`define MASK_HI5 8'hf8
`define PAT_IMM_GRP 8'h80
`define PAT_ADD_ACC 8'h04
`define PAT_ADC_RR 8'h10
`define PAT_ADC_ACC 8'h14
`define PAT_INC_GRP 8'hfe
`define PAT_INC_SHORT 8'h40
`define PAT_SUB_RR 8'h28
`define REG_ADD 3'h0
`define REG_ADC 3'h2
`define REG_INC 3'h0
`define MOD_REG 2'h3
`define BIT_W 0
`define BIT_D 1
`define MODRM_MOD_HI 7
`define MODRM_MOD_LO 6
`define MODRM_REG_HI 5
`define MODRM_REG_LO 3
`define SHORT_REG_HI 2
`define SHORT_REG_LO 0

`define CLK_2 4'h2
`define CLK_3 4'h3
`define CLK_4 4'h4
`define CLK_5 4'h5
`define CLK_6 4'h6
`define CLK_7 4'h7
`define CLK_8 4'h8
`define CLK_NONE 4'h0

`endif

/* hdl/decode_pkg.sv */
package decode_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_CARRY_INV, OP_FLAGS_OUT, OP_FLAGS_POP, OP_FLAGS_PUSH,
    OP_FLAGS_IN, OP_CARRY_SET, OP_DIR_SET, OP_INT_SET, OP_ADD_IMM,
    OP_ADD_ACC, OP_ADC_RR, OP_ADC_IMM, OP_ADC_ACC, OP_INC_RM,
    OP_INC_SHORT, OP_SUB_RR
  } op_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
  } fetch_type;

  typedef struct packed {
    op_type op;
    logic known;
    logic wide;
    logic dir_to_reg;
    logic sign_ext;
    logic mem_operand;
    logic no_count;
    logic [2:0] short_reg;
    logic [3:0] clocks;
  } decode_type;
endpackage : decode_pkg

/* hdl/clock_count_lookup.sv */
`timescale 1ns/1ps
`default_nettype none
`include "decode_defs.svh"
module clock_count_lookup
  import decode_pkg::*;
(
  input wire decode_pkg::op_type op, // decoded operation
  input wire logic mem_operand, // operand in memory
  output logic [3:0] clocks, // execution clocks
  output logic no_count // count not defined
);
  always_comb
  begin
    no_count = 1'b0;
    unique case (op)
      OP_CARRY_INV: clocks = `CLK_2;
      OP_FLAGS_OUT: clocks = `CLK_2;
      OP_FLAGS_POP: clocks = `CLK_5;
      OP_FLAGS_PUSH: clocks = `CLK_4;
      OP_FLAGS_IN: clocks = `CLK_3;
      OP_CARRY_SET: clocks = `CLK_2;
      OP_DIR_SET:
      begin
        clocks = `CLK_NONE;
        no_count = 1'b1;
      end
      OP_INT_SET: clocks = `CLK_8;
      OP_ADD_IMM: clocks = mem_operand ? `CLK_7 : `CLK_2;
      OP_ADD_ACC: clocks = `CLK_2;
      OP_ADC_RR:
        clocks = mem_operand ? `CLK_6 : `CLK_2;
      OP_ADC_IMM: clocks = mem_operand ? `CLK_7 : `CLK_2;
      OP_ADC_ACC: clocks = `CLK_2;
      OP_INC_RM: clocks = mem_operand ? `CLK_6 : `CLK_2;
      OP_INC_SHORT: clocks = `CLK_2;
      OP_SUB_RR: clocks = `CLK_2;
      default: clocks = `CLK_NONE;
    endcase
  end
endmodule : clock_count_lookup
`default_nettype wire

/* hdl/flag_arith_opcode_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "decode_defs.svh"
module flag_arith_opcode_decode
  import decode_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic sys_rst, // sync reset, high
  input wire logic clk_en, // freezes state when low
  input wire logic in_valid, // fetch presents a byte pair
  input wire decode_pkg::fetch_type in_fetch, // opcode and modrm
  output logic out_valid, // decode result valid
  output decode_pkg::decode_type out_dec // registered decode
);
  import decode_pkg::*;

  // ==========================================================
  // field extraction
  // the modrm byte is split here once so every family below reads
  // the same named fields
  logic [7:0] opc;
  logic [1:0] mod_f;
  logic [2:0] reg_f;
  logic mem_f;
  logic width_f;
  logic dir_f;
  logic [2:0] short_f;

  assign opc = in_fetch.opcode;
  assign mod_f = in_fetch.modrm[`MODRM_MOD_HI:`MODRM_MOD_LO];
  assign reg_f = in_fetch.modrm[`MODRM_REG_HI:`MODRM_REG_LO];
  // forms without a modrm byte never look at mem_f, so whatever the
  // fetch leaves in the second byte for them is harmless
  assign mem_f = (mod_f != `MOD_REG);
  assign width_f = opc[`BIT_W];
  assign dir_f = opc[`BIT_D];
  assign short_f = opc[`SHORT_REG_HI:`SHORT_REG_LO];

  // ==========================================================
  // exact single-byte flag opcodes
  // each of these owns its whole byte, no modrm is consulted
  logic hit_carry_inv;
  logic hit_flags_out;
  logic hit_flags_pop;
  logic hit_flags_push;
  logic hit_flags_in;
  logic hit_carry_set;
  logic hit_dir_set;
  logic hit_int_set;

  assign hit_carry_inv = (opc == `OPC_CARRY_INV);
  assign hit_flags_out = (opc == `OPC_FLAGS_OUT);
  assign hit_flags_pop = (opc == `OPC_FLAGS_POP);
  assign hit_flags_push = (opc == `OPC_FLAGS_PUSH);
  assign hit_flags_in = (opc == `OPC_FLAGS_IN);
  assign hit_carry_set = (opc == `OPC_CARRY_SET);
  assign hit_dir_set = (opc == `OPC_DIR_SET);
  assign hit_int_set = (opc == `OPC_INT_SET);

  // ==========================================================
  // opcode families, matched on their fixed upper bits
  // the immediate and increment groups share a first byte with other
  // operations, so they also need the reg field of the modrm byte;
  // the plain register add forms are deliberately left undecoded
  logic fam_imm;
  logic fam_add_acc;
  logic fam_adc_rr;
  logic fam_adc_acc;
  logic fam_inc_rm;
  logic fam_inc_short;
  logic fam_sub_rr;

  assign fam_imm = ((opc & `MASK_HI6) == `PAT_IMM_GRP);
  assign fam_add_acc = ((opc & `MASK_HI7) == `PAT_ADD_ACC);
  assign fam_adc_rr = ((opc & `MASK_HI6) == `PAT_ADC_RR);
  assign fam_adc_acc = ((opc & `MASK_HI7) == `PAT_ADC_ACC);
  assign fam_inc_rm = ((opc & `MASK_HI7) == `PAT_INC_GRP);
  assign fam_inc_short = ((opc & `MASK_HI5) == `PAT_INC_SHORT);
  assign fam_sub_rr = ((opc & `MASK_HI6) == `PAT_SUB_RR);

  // ==========================================================
  // operation select
  // exact opcodes go first; no later family pattern can match a byte
  // that an exact match owns, so the chain order never decides between them
  op_type op_nxt;
  logic mem_nxt;
  logic sext_nxt;

  always_comb
  begin
    op_nxt = OP_NONE;
    mem_nxt = 1'b0;
    sext_nxt = 1'b0;
    if (hit_carry_inv)
      op_nxt = OP_CARRY_INV;
    else if (hit_flags_out)
      op_nxt = OP_FLAGS_OUT;
    else if (hit_flags_pop)
      op_nxt = OP_FLAGS_POP;
    else if (hit_flags_push)
      op_nxt = OP_FLAGS_PUSH;
    else if (hit_flags_in)
      op_nxt = OP_FLAGS_IN;
    else if (hit_carry_set)
      op_nxt = OP_CARRY_SET;
    else if (hit_dir_set)
      op_nxt = OP_DIR_SET;
    else if (hit_int_set)
      op_nxt = OP_INT_SET;
    else if (fam_imm && reg_f == `REG_ADD)
    begin
      op_nxt = OP_ADD_IMM;
      mem_nxt = mem_f;
      sext_nxt = dir_f;
    end
    else if (fam_imm && reg_f == `REG_ADC)
    begin
      op_nxt = OP_ADC_IMM;
      mem_nxt = mem_f;
      sext_nxt = dir_f;
    end
    else if (fam_add_acc)
      op_nxt = OP_ADD_ACC;
    else if (fam_adc_rr)
    begin
      op_nxt = OP_ADC_RR;
      mem_nxt = mem_f;
    end
    else if (fam_adc_acc)
      op_nxt = OP_ADC_ACC;
    else if (fam_inc_rm && reg_f == `REG_INC)
    begin
      op_nxt = OP_INC_RM;
      mem_nxt = mem_f;
    end
    else if (fam_inc_short)
      op_nxt = OP_INC_SHORT;
    else if (fam_sub_rr)
    begin
      op_nxt = OP_SUB_RR;
      mem_nxt = mem_f;
    end
  end

  // ==========================================================
  // clock count
  // the lookup knows one count per operation and operand kind; the
  // register add-carry memory forms then split on the direction bit
  logic [3:0] lk_clocks;
  logic lk_none;
  logic [3:0] clk_nxt;

  clock_count_lookup u_lookup (
    .op(op_nxt),
    .mem_operand(mem_nxt),
    .clocks(lk_clocks),
    .no_count(lk_none)
  );

  always_comb
  begin
    clk_nxt = lk_clocks;
    // to-memory form (direction bit clear) takes longer than from-memory
    if (op_nxt == OP_ADC_RR && mem_nxt && !dir_f)
      clk_nxt = `CLK_7;
    // a memory operand on the register subtract is outside this block,
    // so clocks reads CLK_NONE rather than a guessed count; no_count stays clear
    if (op_nxt == OP_SUB_RR && mem_nxt)
      clk_nxt = `CLK_NONE;
  end

  // ==========================================================
  // result assembly
  // wide and dir_to_reg are the raw low opcode bits for every form;
  // the consumer decides whether a form gives them a meaning
  decode_type dec_nxt;

  always_comb
  begin
    dec_nxt = '0;
    dec_nxt.op = op_nxt;
    dec_nxt.known = (op_nxt != OP_NONE);
    dec_nxt.wide = width_f;
    dec_nxt.dir_to_reg = dir_f;
    dec_nxt.sign_ext = sext_nxt;
    dec_nxt.mem_operand = mem_nxt;
    dec_nxt.no_count = lk_none;
    dec_nxt.short_reg = short_f;
    dec_nxt.clocks = clk_nxt;
  end

  // ==========================================================
  // output registers
  // out_valid copies in_valid while clk_en is high and holds while it is low; the decode word is only loaded on
  // a take, so it stays readable until the next one arrives
  // reset is honoured even with clk_en low so a frozen core can still
  // be brought back to a known state
  logic out_valid_r;
  decode_type out_dec_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      out_valid_r <= 1'b0;
    else if (clk_en)
      out_valid_r <= in_valid;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      out_dec_r <= '0;
    else if (clk_en && in_valid)
      out_dec_r <= dec_nxt;
  end

  assign out_valid = out_valid_r;
  assign out_dec = out_dec_r;
endmodule : flag_arith_opcode_decode
`default_nettype wire

/* bench/decode_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module decode_monitor
  import decode_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic clk_en, // enable
  input wire logic in_valid, // request
  input wire decode_pkg::fetch_type in_fetch, // byte pair
  input wire logic out_valid, // result valid
  input wire decode_pkg::decode_type out_dec // result
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire tk = clk_en && in_valid;
  wire [7:0] oc = in_fetch.opcode;
  // =====
  // decode checks, answer one cycle after the take
  property p_cinv;
    tk && oc == 8'hf5 |=> out_dec.op == OP_CARRY_INV;
  endproperty
  a_cinv: assert property (p_cinv) else $error("carry invert");
  property p_cset;
    tk && oc == 8'hf9 |=> out_dec.op == OP_CARRY_SET && out_dec.clocks == 4'h2;
  endproperty
  a_cset: assert property (p_cset) else $error("carry set");
  property p_short;
    tk && oc[7:3] == 5'h08 |=> out_dec.op == OP_INC_SHORT &&
      out_dec.short_reg == $past(oc[2:0]);
  endproperty
  a_short: assert property (p_short) else $error("short increment");
  property p_out; tk && oc == 8'h9f |=> out_dec.clocks == 4'h2; endproperty
  a_out: assert property (p_out) else $error("flags out");
  property p_pop; tk && oc == 8'h9d |=> out_dec.clocks == 4'h5; endproperty
  a_pop: assert property (p_pop) else $error("flags pop");
  property p_psh; tk && oc == 8'h9c |=> out_dec.clocks == 4'h4; endproperty
  a_psh: assert property (p_psh) else $error("flags push");
  property p_in; tk && oc == 8'h9e |=> out_dec.clocks == 4'h3; endproperty
  a_in: assert property (p_in) else $error("flags in");
  property p_dir; tk && oc == 8'hfd |=> out_dec.no_count; endproperty
  a_dir: assert property (p_dir) else $error("direction set");
  property p_int; tk && oc == 8'hfb |=> out_dec.clocks == 4'h8; endproperty
  a_int: assert property (p_int) else $error("interrupt set");
  property p_w; tk |=> out_valid && out_dec.wide == $past(oc[0]); endproperty
  a_w: assert property (p_w) else $error("width bit");
endmodule : decode_monitor
bind flag_arith_opcode_decode decode_monitor i_decode_monitor (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .in_valid(in_valid),
  .in_fetch(in_fetch),
  .out_valid(out_valid),
  .out_dec(out_dec)
);
`default_nettype wire

/* bench/fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fetch_model
  import decode_pkg::*;
(
  input wire logic ref_clk, // clock
  output logic in_valid, // byte pair present
  output decode_pkg::fetch_type in_fetch // opcode and modrm
);
  initial in_valid = 0;
  initial in_fetch = 16'h5a5a;
  // idle bus shows the inverse so stale bytes are never mistaken for data
  // start keeps valid high, so two starts in a row give back-to-back beats
  task start(input logic [7:0] o, input logic [7:0] m);
    @(negedge ref_clk);
    in_valid = 1;
    in_fetch = {o, m};
  endtask : start
  task go_idle;
    @(negedge ref_clk);
    in_valid = 0;
    in_fetch = ~in_fetch;
  endtask : go_idle
  task present(input logic [7:0] o, input logic [7:0] m);
    start(o, m);
    go_idle;
  endtask : present
endmodule : fetch_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
  import decode_pkg::*;
  logic ref_clk = 0, sys_rst = 1, clk_en = 1, in_valid, out_valid;
  fetch_type in_fetch;
  decode_type out_dec;
  int err_count = 0, tests_run = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  fetch_model i_fetch_model (.ref_clk(ref_clk), .in_valid(in_valid),
    .in_fetch(in_fetch));
  flag_arith_opcode_decode i_flag_arith_opcode_decode (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .in_valid(in_valid),
    .in_fetch(in_fetch), .out_valid(out_valid), .out_dec(out_dec));
  // =====
  // helpers
  task wrap_up;
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 500)
    begin
      err_count++;
      wrap_up;
    end
  end
  task dec(input logic [7:0] o, m, input op_type op, input logic [3:0] c);
    i_fetch_model.present(o, m);
    `CHK(out_valid, 1'b1)
    `CHK(out_dec.op, op)
    `CHK(out_dec.clocks, c)
    `CHK(out_dec.known, op != OP_NONE)
  endtask : dec
  // =====
  // scenarios
  task t_flags;
    logic [7:0] oc[7] = '{8'hf5, 8'h9f, 8'h9d, 8'h9c, 8'h9e, 8'hf9, 8'hfb};
    logic [3:0] cl[7] = '{4'h2, 4'h2, 4'h5, 4'h4, 4'h3, 4'h2, 4'h8};
    op_type ops[7] = '{OP_CARRY_INV, OP_FLAGS_OUT, OP_FLAGS_POP,
      OP_FLAGS_PUSH, OP_FLAGS_IN, OP_CARRY_SET, OP_INT_SET};
    for (int i = 0; i < 7; i++) dec(oc[i], 8'hc0, ops[i], cl[i]);
    dec(8'hfd, 8'hc0, OP_DIR_SET, 4'h0);
    `CHK(out_dec.no_count, 1'b1)
  endtask : t_flags
  task t_arith;
    dec(8'h80, 8'hc0, OP_ADD_IMM, 4'h2);
    dec(8'h83, 8'h00, OP_ADD_IMM, 4'h7);
    `CHK(out_dec.sign_ext, 1'b1)
    dec(8'h05, 8'h00, OP_ADD_ACC, 4'h2);
    dec(8'h13, 8'hc0, OP_ADC_RR, 4'h2);
    `CHK({out_dec.wide, out_dec.dir_to_reg}, 2'h3)
    dec(8'h10, 8'h00, OP_ADC_RR, 4'h7);
    `CHK(out_dec.mem_operand, 1'b1)
    dec(8'h12, 8'h00, OP_ADC_RR, 4'h6);
    dec(8'h81, 8'hd0, OP_ADC_IMM, 4'h2);
    dec(8'h80, 8'h10, OP_ADC_IMM, 4'h7);
    dec(8'h14, 8'h00, OP_ADC_ACC, 4'h2);
  endtask : t_arith
  task t_inc_sub;
    dec(8'hfe, 8'hc0, OP_INC_RM, 4'h2);
    dec(8'hff, 8'h00, OP_INC_RM, 4'h6);
    dec(8'h43, 8'h00, OP_INC_SHORT, 4'h2);
    `CHK(out_dec.short_reg, 3'h3)
    dec(8'h29, 8'hc0, OP_SUB_RR, 4'h2);
    `CHK({out_dec.wide, out_dec.dir_to_reg}, 2'h2)
    dec(8'h2b, 8'h00, OP_SUB_RR, 4'h0);
  endtask : t_inc_sub
  task t_burst;
    i_fetch_model.start(8'hf9, 8'hc0);
    i_fetch_model.start(8'h9d, 8'hc0);
    `CHK(out_valid, 1'b1)
    `CHK(out_dec.op, OP_CARRY_SET)
    i_fetch_model.go_idle;
    `CHK(out_valid, 1'b1)
    `CHK(out_dec.clocks, 4'h5)
    @(negedge ref_clk);
    `CHK(out_valid, 1'b0)
  endtask : t_burst
  task t_hold;
    dec(8'hf5, 8'hc0, OP_CARRY_INV, 4'h2);
    clk_en = 0;
    i_fetch_model.present(8'hf9, 8'hc0);
    `CHK(out_dec.op, OP_CARRY_INV)
    clk_en = 1;
    dec(8'h01, 8'hc0, OP_NONE, 4'h0);
    `CHK(out_dec.known, 1'b0)
    sys_rst = 1;
    @(negedge ref_clk);
    sys_rst = 0;
    `CHK(out_valid, 1'b0)
    `CHK(out_dec, '0)
    dec(8'h9e, 8'hc0, OP_FLAGS_IN, 4'h3);
  endtask : t_hold
  initial
  begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 0;
    `CHK(out_dec, '0)
    `CHK(out_valid, 1'b0)
    t_flags;
    t_arith;
    t_inc_sub;
    t_burst;
    t_hold;
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
